// ===== hw/css_params.svh
// constants of the card supply sequencer: offsets, fields, resets, timing
// assumes one 20 MHz clock and an APB bus with byte addresses
`ifndef CSS_PARAMS_SVH
`define CSS_PARAMS_SVH

// ----------------------------------------------------------------------
// register indices and byte addresses (index times four)
// ----------------------------------------------------------------------
`define CSS_IDX_CTRL 16'hFE03
`define CSS_IDX_TMR 16'hFE04
`define CSS_ADDR_CTRL ({`CSS_IDX_CTRL, 2'b00})
`define CSS_ADDR_TMR ({`CSS_IDX_TMR, 2'b00})
`define CSS_ADDR_ISTAT 18'h3F820
`define CSS_ADDR_IEN 18'h3F824
`define CSS_ADDR_ICLR 18'h3F828

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CSS_SEL_HI 7
`define CSS_SEL_LO 6
`define CSS_FAULT_BIT 5
`define CSS_RSTART_BIT 4
`define CSS_GOOD_BIT 3
`define CSS_PWROFF_BIT 0
`define CSS_OFF_HI 7
`define CSS_OFF_LO 4
`define CSS_SET_HI 3
`define CSS_SET_LO 0
`define CSS_IRQ_SETTLE 0
`define CSS_IRQ_CARD 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CSS_RST_CTRL 8'h00
`define CSS_RST_TMR 8'h0F

// ----------------------------------------------------------------------
// timing: one slow tick is 30.5 us, counted in 50 ns clock cycles
// ----------------------------------------------------------------------
`define CSS_CLK_NS 50
`define CSS_TICK_NS 30500
`define CSS_TICK_CYC (`CSS_TICK_NS / `CSS_CLK_NS)

`endif

// ===== hw/css_pkg.sv
// types of the card supply sequencer
// assumes the constants header is compiled alongside
package css_pkg;

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    CSS_IDLE = 4'b0000,
    CSS_PWRUP = 4'b0001,
    CSS_ACTIVE = 4'b0010,
    CSS_OFF_WAIT = 4'b0011,
    CSS_D_RST = 4'b0100,
    CSS_D_CLK = 4'b0101,
    CSS_D_IO = 4'b0110,
    CSS_D_VCC = 4'b0111
  } css_state_e;

  // ----------------------------------------------------------------------
  // bus and contact carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
  } css_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } css_apb_rsp_s;

  typedef struct packed {
    logic card_rst_n;    // card reset contact, low = held in reset
    logic clk_en;        // card clock running
    logic io_en;         // io contact released, 0 = driven low
    logic vcc_on;        // card supply switched on
    logic [1:0] level;   // selected supply level
  } css_contact_s;

endpackage : css_pkg

// ===== hw/css_top.sv
// card supply sequencer: activation, settle check, normal and forced
// deactivation, and the chip power-off request, with an APB register file
// assumes asynchronous pins are synchronised here and a single 20 MHz clock
`timescale 1ns/1ps
`include "css_params.svh"

module css_top (
  input wire logic clock,
  input wire logic resetn,
  input wire css_pkg::css_apb_req_s apb_req,   // apb request from master
  output css_pkg::css_apb_rsp_s apb_rsp,       // apb answer
  input wire logic card_present,               // debounced presence pin
  input wire logic supply_good,                // card supply stable pin
  input wire logic core_fault,                 // core supply fault pin
  input wire logic bus_power,                  // bus power present pin
  output css_pkg::css_contact_s contacts,      // card contact controls
  output logic chip_power_off_req,             // whole chip power down
  output logic irq                              // level interrupt
);
  import css_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    css_state_e st;             // sequencer state
    logic [2:0][3:0] sync;      // pin synchronisers, stage by bit
    logic [3:0] stable;         // filtered pin levels
    logic [1:0] sel;            // card supply select
    logic rstart;               // ready start enable
    logic pwroff;               // chip power off bit
    logic lock;                 // forced deactivation lockout
    logic [7:0] tmr;            // off delay and settle fields
    logic [1:0] istat;          // sticky interrupt status
    logic [1:0] ien;            // interrupt enables
    logic [9:0] tick_cnt;       // slow tick prescaler
    logic tick;                 // slow tick pulse
    logic [3:0] cnt;            // settle or off delay tick count
    css_contact_s con;          // contact outputs
    logic pwr_req;              // power off request output
    logic irq;                  // interrupt output
    css_apb_rsp_s rsp;          // bus answer
  } css_regs_s;

  css_regs_s r_ff;
  css_regs_s nxt_r;

  // pin order inside the synchroniser vector
  localparam int PIN_CARD = 0;
  localparam int PIN_GOOD = 1;
  localparam int PIN_FLT = 2;
  localparam int PIN_BUS = 3;
  localparam logic [9:0] TICK_LAST = 10'(`CSS_TICK_CYC - 1);

  // ----------------------------------------------------------------------
  // events seen by comparing the agreeing stages with the filtered level
  // ----------------------------------------------------------------------
  logic [3:0] agree;      // second and third stage agree per pin
  logic card_evt;         // card inserted or removed
  logic good_fall;        // supply good dropped
  logic fault_rise;       // core fault arrived
  logic emerg;            // card or fault cause of forced deactivation
  logic expire;           // settle interval ended
  logic [3:0] settle;     // settle field
  logic [3:0] offd;       // off delay field
  logic acc;              // apb access edge
  logic [7:0] ctrl_rd;    // control register readback

  assign agree = ~(r_ff.sync[1] ^ r_ff.sync[2]);
  // any change of presence counts, either direction
  assign card_evt = agree[PIN_CARD] &&
    (r_ff.sync[2][PIN_CARD] != r_ff.stable[PIN_CARD]);
  assign good_fall = agree[PIN_GOOD] && !r_ff.sync[2][PIN_GOOD] &&
    r_ff.stable[PIN_GOOD];
  assign fault_rise = agree[PIN_FLT] && r_ff.sync[2][PIN_FLT] &&
    !r_ff.stable[PIN_FLT];
  assign emerg = card_evt || fault_rise;
  assign settle = r_ff.tmr[`CSS_SET_HI:`CSS_SET_LO];
  assign offd = r_ff.tmr[`CSS_OFF_HI:`CSS_OFF_LO];
  // a zero field never expires
  assign expire = (r_ff.st == CSS_PWRUP) && (settle != 4'h0) &&
    (r_ff.cnt == settle);
  assign acc = apb_req.psel && apb_req.penable && r_ff.rsp.pready;
  // fault bit reads 0 while faulted, good bit is status only
  assign ctrl_rd = {r_ff.sel, !r_ff.stable[PIN_FLT], r_ff.rstart,
    r_ff.stable[PIN_GOOD], 2'b00, r_ff.pwroff};

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    nxt_r.tick = 1'b0;
    // three stage synchronisers, first stage read only by the second
    nxt_r.sync[0] = {bus_power, core_fault, supply_good, card_present};
    nxt_r.sync[1] = r_ff.sync[0];
    nxt_r.sync[2] = r_ff.sync[1];
    for (int i = 0; i < 4; i++) begin
      if (agree[i]) begin
        nxt_r.stable[i] = r_ff.sync[2][i];
      end
    end

    // free running 30.5 us tick; timers are thus exact to one tick
    if (r_ff.tick_cnt == TICK_LAST) begin
      nxt_r.tick_cnt = 10'h000;
      nxt_r.tick = 1'b1;
    end else begin
      nxt_r.tick_cnt = r_ff.tick_cnt + 10'h001;
    end

    // apb: ready raised for the access cycle after every setup cycle
    nxt_r.rsp.pready = apb_req.psel && !apb_req.penable;
    if (apb_req.psel && !apb_req.penable) begin
      nxt_r.rsp.pslverr = 1'b0;
      nxt_r.rsp.prdata = 32'h0000_0000;
      case (apb_req.paddr)
        `CSS_ADDR_CTRL: begin
          nxt_r.rsp.prdata = {24'h000000, ctrl_rd};
        end
        `CSS_ADDR_TMR: begin
          nxt_r.rsp.prdata = {24'h000000, r_ff.tmr};
        end
        `CSS_ADDR_ISTAT: begin
          nxt_r.rsp.prdata = {30'h0000_0000, r_ff.istat};
        end
        `CSS_ADDR_IEN: begin
          nxt_r.rsp.prdata = {30'h0000_0000, r_ff.ien};
        end
        `CSS_ADDR_ICLR: begin
          // write only, reads as zero
          nxt_r.rsp.prdata = 32'h0000_0000;
        end
        default: begin
          nxt_r.rsp.pslverr = 1'b1;
        end
      endcase
    end

    // register writes and read side effects at the access edge
    if (acc && apb_req.pwrite) begin
      case (apb_req.paddr)
        `CSS_ADDR_CTRL: begin
          // both select bits move together in one write
          nxt_r.sel = apb_req.pwdata[`CSS_SEL_HI:`CSS_SEL_LO];
          nxt_r.rstart = apb_req.pwdata[`CSS_RSTART_BIT];
          nxt_r.pwroff = apb_req.pwdata[`CSS_PWROFF_BIT];
        end
        `CSS_ADDR_TMR: begin
          nxt_r.tmr = apb_req.pwdata[7:0];
        end
        `CSS_ADDR_IEN: begin
          nxt_r.ien = apb_req.pwdata[1:0];
        end
        `CSS_ADDR_ICLR: begin
          nxt_r.istat = r_ff.istat & ~apb_req.pwdata[1:0];
        end
        default: begin
          nxt_r.istat = nxt_r.istat;
        end
      endcase
    end
    if (acc && !apb_req.pwrite && apb_req.paddr == `CSS_ADDR_ISTAT) begin
      // reading the status clears it
      nxt_r.istat = 2'b00;
    end

    // lockout releases once select is zero, cleared by software or by a fault
    if (r_ff.sel == 2'b00) begin
      nxt_r.lock = 1'b0;
    end
    // a card event always raises its flag; set beats any clear
    if (card_evt) begin
      nxt_r.istat[`CSS_IRQ_CARD] = 1'b1;
    end

    // sequencer
    case (r_ff.st)
      CSS_IDLE: begin
        // start needs a nonzero level and no pending lockout
        if (r_ff.sel != 2'b00 && !r_ff.lock) begin
          nxt_r.con.level = r_ff.sel;
          nxt_r.con.vcc_on = 1'b1;
          nxt_r.cnt = 4'h0;
          nxt_r.st = CSS_PWRUP;
        end
      end
      CSS_PWRUP: begin
        if (r_ff.tick && r_ff.cnt != 4'hF) begin
          nxt_r.cnt = r_ff.cnt + 4'h1;
        end
        if (emerg || good_fall) begin
          // forced, no off delay
          nxt_r.lock = 1'b1;
          nxt_r.st = CSS_D_RST;
        end else if (expire) begin
          nxt_r.istat[`CSS_IRQ_SETTLE] = 1'b1;
          if (r_ff.stable[PIN_GOOD]) begin
            nxt_r.st = CSS_ACTIVE;
          end else begin
            // supply never came good
            nxt_r.istat[`CSS_IRQ_CARD] = 1'b1;
            nxt_r.sel = 2'b00;
            nxt_r.st = CSS_D_RST;
          end
        end else if (r_ff.sel == 2'b00) begin
          nxt_r.st = CSS_D_RST;
        end else if (r_ff.rstart && r_ff.stable[PIN_GOOD]) begin
          nxt_r.st = CSS_ACTIVE;
        end
      end
      CSS_ACTIVE: begin
        nxt_r.con.card_rst_n = 1'b1;
        nxt_r.con.clk_en = 1'b1;
        nxt_r.con.io_en = 1'b1;
        if (emerg || good_fall) begin
          nxt_r.lock = 1'b1;
          nxt_r.st = CSS_D_RST;
        end else if (r_ff.sel == 2'b00) begin
          nxt_r.cnt = 4'h0;
          // zero off delay goes straight to deactivation
          nxt_r.st = (offd == 4'h0) ? CSS_D_RST : CSS_OFF_WAIT;
        end
      end
      CSS_OFF_WAIT: begin
        if (r_ff.tick) begin
          nxt_r.cnt = r_ff.cnt + 4'h1;
        end
        if (emerg || good_fall) begin
          nxt_r.lock = 1'b1;
          nxt_r.st = CSS_D_RST;
        end else if (r_ff.cnt == offd) begin
          nxt_r.st = CSS_D_RST;
        end
      end
      CSS_D_RST: begin
        nxt_r.con.card_rst_n = 1'b0;
        nxt_r.st = CSS_D_CLK;
      end
      CSS_D_CLK: begin
        nxt_r.con.clk_en = 1'b0;
        nxt_r.st = CSS_D_IO;
      end
      CSS_D_IO: begin
        nxt_r.con.io_en = 1'b0;
        nxt_r.st = CSS_D_VCC;
      end
      CSS_D_VCC: begin
        // supply goes last, after all contacts are low
        nxt_r.con.vcc_on = 1'b0;
        nxt_r.con.level = 2'b00;
        nxt_r.st = CSS_IDLE;
      end
      default: begin
        nxt_r.st = CSS_IDLE;
      end
    endcase

    // core fault wipes the select at once, overriding any write
    if (fault_rise) begin
      nxt_r.sel = 2'b00;
    end

    // power off held back while bus power is present
    nxt_r.pwr_req = r_ff.pwroff && !r_ff.stable[PIN_BUS];
    nxt_r.irq = |(nxt_r.istat & nxt_r.ien);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      r_ff <= '0;
      r_ff.st <= CSS_IDLE;
      r_ff.sel <= 2'(`CSS_RST_CTRL >> `CSS_SEL_LO);
      r_ff.tmr <= `CSS_RST_TMR;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign apb_rsp = r_ff.rsp;
  assign contacts = r_ff.con;
  assign chip_power_off_req = r_ff.pwr_req;
  assign irq = r_ff.irq;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking css_cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  chk_sel_start: assert property (
    r_ff.st == CSS_IDLE && r_ff.sel != 2'b00 && !r_ff.lock |=>
      r_ff.st == CSS_PWRUP && contacts.vcc_on &&
      contacts.level == $past(r_ff.sel))
    else $error("activation did not start");

  chk_deact_order: assert property (
    r_ff.st == CSS_D_RST |=> !contacts.card_rst_n && contacts.vcc_on
      ##1 !contacts.clk_en && contacts.vcc_on
      ##1 !contacts.io_en && contacts.vcc_on
      ##1 !contacts.vcc_on && r_ff.st == CSS_IDLE)
    else $error("deactivation out of order");

  chk_fault_clear: assert property (
    fault_rise |=> r_ff.sel == 2'b00 && !ctrl_rd[`CSS_FAULT_BIT])
    else $error("fault did not clear select");

  chk_rdy_start: assert property (
    r_ff.st == CSS_PWRUP && r_ff.rstart && r_ff.stable[PIN_GOOD] &&
      r_ff.sel != 2'b00 && !emerg && !good_fall |=>
      r_ff.st == CSS_ACTIVE)
    else $error("ready start not honoured");

  chk_settle_fail: assert property (
    expire && !r_ff.stable[PIN_GOOD] && !emerg && !good_fall |=>
      r_ff.istat[`CSS_IRQ_CARD] && r_ff.sel == 2'b00 &&
      r_ff.st == CSS_D_RST)
    else $error("settle failure not handled");

  chk_settle_flag: assert property (
    expire && !emerg && !good_fall |=> r_ff.istat[`CSS_IRQ_SETTLE])
    else $error("settle flag missing");

  chk_off_zero: assert property (
    r_ff.st == CSS_ACTIVE && r_ff.sel == 2'b00 && offd == 4'h0 &&
      !emerg && !good_fall |=> r_ff.st == CSS_D_RST)
    else $error("zero off delay waited");

  chk_emerg_fast: assert property (
    (r_ff.st == CSS_ACTIVE || r_ff.st == CSS_OFF_WAIT) && card_evt |=>
      r_ff.st == CSS_D_RST ##1 !contacts.card_rst_n)
    else $error("emergency deactivation delayed");

  chk_pwroff_bus: assert property (
    r_ff.stable[PIN_BUS] |=> !chip_power_off_req)
    else $error("power off while bus powered");

  // off delay keeps the contacts up until the count reaches the field
  chk_off_hold: assert property (
    r_ff.st == CSS_OFF_WAIT && r_ff.cnt != offd && !emerg && !good_fall |=>
      r_ff.st == CSS_OFF_WAIT && contacts.card_rst_n)
    else $error("off delay cut short");

  // covers for the main scenarios, forced stops included

  cov_activate: cover property (
    r_ff.st == CSS_PWRUP ##1 r_ff.st == CSS_ACTIVE);
  cov_settle_fail: cover property (
    expire && !r_ff.stable[PIN_GOOD]);
  cov_off_delay: cover property (
    r_ff.st == CSS_OFF_WAIT ##1 r_ff.st == CSS_D_RST);
  cov_fault_stop: cover property (
    (fault_rise && r_ff.st == CSS_ACTIVE) ##1 r_ff.st == CSS_D_RST);
  cov_card_stop: cover property (
    (card_evt && r_ff.st == CSS_ACTIVE) ##1 r_ff.st == CSS_D_RST);

endmodule : css_top

// ===== bench/css_card_model.sv
// card side model: the card supply settles some cycles after switch-on
// assumes the contact struct of the sequencer; bench sets ramp and fault
`timescale 1ns/1ps

module css_card_model (
  input wire logic clock,
  input wire logic resetn,
  input wire css_pkg::css_contact_s contacts,
  input wire logic [15:0] ramp_cyc,  // cycles until supply is stable
  input wire logic dead,             // commanded: supply never settles
  output logic supply_good
);
  import css_pkg::*;

  // ----------------------------------------------------------------
  // supply ramp
  // ----------------------------------------------------------------
  logic [15:0] cnt_ff;  // cycles since supply switched on

  // good is lost at once when the supply is off, no slow decay modelled
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 16'h0000;
      supply_good <= 1'b0;
    end else if (!contacts.vcc_on || dead) begin
      cnt_ff <= 16'h0000;
      supply_good <= 1'b0;
    end else begin
      // slow or prompt settling, as the bench sets it
      if (cnt_ff < ramp_cyc) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
      supply_good <= (cnt_ff >= ramp_cyc);
    end
  end
endmodule : css_card_model

// ===== bench/testbench.sv
// self-checking bench of the card supply sequencer, scenario tasks
// assumes css_top, css_card_model and the constants header
`timescale 1ns/1ps
`include "css_params.svh"

module testbench;
  import css_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic resetn = 1'b0;
  css_apb_req_s apb_req = '0;
  css_apb_rsp_s apb_rsp;
  logic card_present = 1'b0;
  logic core_fault = 1'b0;
  logic bus_power = 1'b0;
  logic supply_good;
  logic dead = 1'b0;             // model supply fails
  logic [15:0] ramp = 16'h0014;  // model settle cycles
  css_contact_s contacts;
  logic chip_power_off_req;
  logic irq;
  logic last_err;                // pslverr of the last transfer
  int err_total = 0;
  int cmp_count = 0;
  localparam int TK = `CSS_TICK_CYC;  // slow tick in clock cycles

  always #25 clock = ~clock;

  css_top u_dut (.clock(clock), .resetn(resetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .card_present(card_present),
    .supply_good(supply_good), .core_fault(core_fault),
    .bus_power(bus_power), .contacts(contacts),
    .chip_power_off_req(chip_power_off_req), .irq(irq));

  css_card_model u_card (.clock(clock), .resetn(resetn),
    .contacts(contacts), .ramp_cyc(ramp), .dead(dead),
    .supply_good(supply_good));

  // ----------------------------------------------------------------
  // reporting and compares
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic fail(input string m);
    err_total++;
    $display("ERROR %0t %s", $time, m);
  endtask : fail

  // register or field value
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) fail($sformatf("value %h expected %h", g, e));
  endtask : chk8

  // single output bit
  task automatic chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e) fail($sformatf("bit %b expected %b", g, e));
  endtask : chk1

  // cycle count inside a window
  task automatic chkn(input int n, input int lo, input int hi);
    cmp_count++;
    if (n < lo || n > hi) fail($sformatf("count %0d out of window", n));
  endtask : chkn

  function automatic logic sig(input int k);
    case (k)
      0: return contacts.card_rst_n;
      1: return contacts.vcc_on;
      2: return chip_power_off_req;
      default: return irq;
    endcase
  endfunction : sig

  // bounded wait for an output level, counted as a compare
  task automatic wait_for(input int k, input logic v, input int lim,
                          output int n);
    n = 0;
    cmp_count++;
    while (sig(k) !== v && n <= lim) begin
      @(posedge clock);
      n++;
    end
    if (n > lim) fail("wait for output timed out");
  endtask : wait_for

  // ----------------------------------------------------------------
  // apb master: setup, then access until pready at an edge
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [17:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, w, a, {24'h000000, d}};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    q = apb_rsp.prdata[7:0];
    last_err = apb_rsp.pslverr;
    apb_req <= '0;
    if (n >= 20) fail("no pready");
  endtask : apb

  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic [7:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  // read and compare a register
  task automatic rdc(input logic [17:0] a, input logic [7:0] e);
    logic [7:0] q;
    apb(1'b0, a, 8'h00, q);
    chk8(q, e);
  endtask : rdc

  // clear select first, since a forced stop locks the sequencer
  task automatic act(input logic [1:0] s, input logic r);
    int n;
    wr(`CSS_ADDR_CTRL, 8'h00);
    wr(`CSS_ADDR_CTRL, {s, 1'b0, r, 4'h0});
    wait_for(1, 1'b1, 8, n);
    chk8({6'h00, contacts.level}, {6'h00, s});
  endtask : act

  // start delay of a deactivation, then one contact per cycle
  task automatic deact(input int lo, input int hi);
    int n;
    wait_for(0, 1'b0, hi, n);
    chkn(n, lo, hi);
    for (int i = 0; i < 4; i++) begin
      chk8({4'h0, contacts.card_rst_n, contacts.clk_en, contacts.io_en,
            contacts.vcc_on}, 8'h07 >> i);
      @(posedge clock);
    end
  endtask : deact

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdc(`CSS_ADDR_CTRL, 8'h20);
    rdc(`CSS_ADDR_TMR, 8'h0F);
    wr(`CSS_ADDR_TMR, 8'hA5);
    rdc(`CSS_ADDR_TMR, 8'hA5);
    wr(`CSS_ADDR_CTRL, 8'h08);
    rdc(`CSS_ADDR_CTRL, 8'h20);
    rdc(18'h3F830, 8'h00);
    chk1(last_err, 1'b1);
    $display("test regs done");
  endtask : t_regs

  // every level, prompt supply, no off delay
  task automatic t_levels;
    int n;
    wr(`CSS_ADDR_TMR, 8'h00);
    for (int s = 1; s < 4; s++) begin
      act(s[1:0], 1'b1);
      wait_for(0, 1'b1, 60, n);
      rdc(`CSS_ADDR_CTRL, {s[1:0], 6'h38});
      wr(`CSS_ADDR_CTRL, 8'h00);
      deact(0, 12);
    end
    $display("test levels done");
  endtask : t_levels

  // slow supply held off by ready-start, then delayed stop
  task automatic t_ready;
    int n;
    ramp <= 16'h0190;
    wr(`CSS_ADDR_TMR, 8'h20);
    act(2'b10, 1'b1);
    repeat (300) @(posedge clock);
    chk1(contacts.card_rst_n, 1'b0);
    wait_for(0, 1'b1, 200, n);
    wr(`CSS_ADDR_CTRL, 8'h00);
    deact(TK - 20, 3 * TK + 20);
    ramp <= 16'h0014;
    $display("test ready done");
  endtask : t_ready

  task automatic t_settle_fail;
    int n;
    dead <= 1'b1;
    wr(`CSS_ADDR_TMR, 8'h02);
    wr(`CSS_ADDR_IEN, 8'h03);
    act(2'b10, 1'b0);
    wait_for(1, 1'b0, 3 * TK + 20, n);
    chkn(n, TK - 20, 3 * TK + 20);
    chk1(irq, 1'b1);
    rdc(`CSS_ADDR_ISTAT, 8'h03);
    rdc(`CSS_ADDR_ISTAT, 8'h00);
    chk1(irq, 1'b0);
    rdc(`CSS_ADDR_CTRL, 8'h20);
    wr(`CSS_ADDR_IEN, 8'h00);
    dead <= 1'b0;
    $display("test settle fail done");
  endtask : t_settle_fail

  // settle pass, then emergency stops with the longest off delay
  task automatic t_emergency;
    int n;
    // two settle ticks, so the interval always outlasts the supply ramp
    wr(`CSS_ADDR_TMR, 8'hF2);
    act(2'b01, 1'b0);
    wait_for(0, 1'b1, 2 * TK + 20, n);
    rdc(`CSS_ADDR_ISTAT, 8'h01);
    card_present <= ~card_present;
    deact(0, 12);
    rdc(`CSS_ADDR_ISTAT, 8'h02);
    wr(`CSS_ADDR_CTRL, 8'h40);
    repeat (20) @(posedge clock);
    chk1(contacts.vcc_on, 1'b0);
    act(2'b01, 1'b0);
    wait_for(0, 1'b1, 2 * TK + 20, n);
    core_fault <= 1'b1;
    deact(0, 12);
    repeat (8) @(posedge clock);
    rdc(`CSS_ADDR_CTRL, 8'h00);
    core_fault <= 1'b0;
    wr(`CSS_ADDR_TMR, 8'hF0);
    act(2'b11, 1'b1);
    wait_for(0, 1'b1, 60, n);
    dead <= 1'b1;
    deact(0, 15);
    dead <= 1'b0;
    $display("test emergency done");
  endtask : t_emergency

  task automatic t_zero;
    int n;
    wr(`CSS_ADDR_TMR, 8'h00);
    wr(`CSS_ADDR_ICLR, 8'h03);
    act(2'b10, 1'b0);
    repeat (3 * TK) @(posedge clock);
    chk1(contacts.card_rst_n, 1'b0);
    rdc(`CSS_ADDR_ISTAT, 8'h00);
    wr(`CSS_ADDR_CTRL, 8'h90);
    wait_for(0, 1'b1, 20, n);
    wr(`CSS_ADDR_CTRL, 8'h00);
    deact(0, 12);
    $display("test zero settle done");
  endtask : t_zero

  // masked event, then enable and clear register
  task automatic t_irq;
    int n;
    wr(`CSS_ADDR_ICLR, 8'h03);
    card_present <= ~card_present;
    repeat (12) @(posedge clock);
    chk1(irq, 1'b0);
    wr(`CSS_ADDR_IEN, 8'h02);
    wait_for(3, 1'b1, 4, n);
    wr(`CSS_ADDR_ICLR, 8'h02);
    wait_for(3, 1'b0, 4, n);
    rdc(`CSS_ADDR_IEN, 8'h02);
    wr(`CSS_ADDR_IEN, 8'h00);
    $display("test irq done");
  endtask : t_irq

  task automatic t_power;
    int n;
    bus_power <= 1'b1;
    // let the pin settle first, or the request pulses for one cycle
    repeat (8) @(posedge clock);
    wr(`CSS_ADDR_CTRL, 8'h01);
    repeat (20) @(posedge clock);
    chk1(chip_power_off_req, 1'b0);
    bus_power <= 1'b0;
    wait_for(2, 1'b1, 10, n);
    wr(`CSS_ADDR_CTRL, 8'h00);
    wait_for(2, 1'b0, 10, n);
    $display("test power done");
  endtask : t_power

  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    t_regs;
    t_levels;
    t_ready;
    t_settle_fail;
    t_emergency;
    t_zero;
    t_irq;
    t_power;
    give_verdict;
  end

  // runs stay below 8000 cycles, so this only trips on a hang
  initial begin
    repeat (50000) @(posedge clock);
    fail("watchdog expired");
    give_verdict;
  end
endmodule : testbench
